// ---- common/crfs_consts.vh ----
// constants for the core regulator fault supervisor
// assumes a 250 MHz system clock and byte register offsets
`ifndef CRFS_CONSTS_VH
`define CRFS_CONSTS_VH

// register byte offsets
`define CRFS_REG_CTRL 4'h0
`define CRFS_REG_STATUS 4'h4
`define CRFS_REG_CODE 4'h8
`define CRFS_REG_MEAN 4'hC

// control register fields and reset value
`define CRFS_CTRL_SLEEP_SINGLE 0
`define CRFS_CTRL_FORCE_SINGLE 1
`define CRFS_CTRL_RESET 2'h1

// status register field positions
`define CRFS_ST_STATE_LSB 0
`define CRFS_ST_EXCESS 4
`define CRFS_ST_LOWV 5
`define CRFS_ST_OVERCUR 6
`define CRFS_ST_BOOT 7

// clock in MHz and switching frequency in kHz
`define CRFS_CLK_MHZ 250
`define CRFS_FSW_KHZ 250
// clock cycles per switching period
`define CRFS_PHASE_DIV ((`CRFS_CLK_MHZ * 1000) / `CRFS_FSW_KHZ)

// switching periods before supply ok is released
`define CRFS_PG_DELAY_TICKS 3072
// consecutive low-voltage periods tolerated
`define CRFS_LOWV_TICKS 32
// overcurrent persistence count that trips
`define CRFS_OC_TRIP 32
// periods the supply ok line is held low after a change
`define CRFS_BLANK_TICKS 8

// operating modes
`define CRFS_MODE_ACTIVE 2'h0
`define CRFS_MODE_DEEP 2'h1
`define CRFS_MODE_DEEPER 2'h2

`endif

// ---- core/crfs_supervisor.v ----
// core regulator fault supervisor: start-up handshake, fault latches,
// two-phase interleaved modulation and off-time current sampling
// assumes comparator results and current samples come from analog
// blocks; the shared supply ok line is resolved outside from oe
//
// Operation
// R1: wait for companions releasing shared line
// R2: sink current detected starts delay timer
// R3: capture target code, leave boot voltage
// R4: delay lasts 3072 switching periods
// R5: supply ok stays low until expiry
// R6: suppress supply ok on code/mode change
// R7: pull own line low when out of window
// R8: above 112 percent: latch, low-side on
// R9: latched and below 102: all gates off
// R10: cycle low-side on and off hysteretically
// R11: excess latch cleared by reset only
// R12: excess threshold follows active mode setpoint
// R13: low threshold 84 percent of mode setpoint
// R14: low over 32 periods latches off
// R15: low latch cleared by enable toggle
// R16: average only active channels' current
// R17: over threshold enables persistence counter
// R18: 32 counts over threshold latches off
// R19: returning under threshold keeps running
// R20: sample current only in off-time
// R21: two ramps run out of phase
// R22: reference from 6 bit target code
// R23: mode decoded from two sleep inputs
// R24: excess or low voltage drops supply ok
// R25: comparators synchronised, reset clears state; boot_reached_i is used unsynchronised
// R26: up/down counter trips at 32
`include "crfs_consts.vh"

module crfs_supervisor #(
   parameter [15:0] PHASE_DIV = `CRFS_PHASE_DIV,
   parameter [11:0] PG_DELAY = `CRFS_PG_DELAY_TICKS,
   parameter CUR_W = 8
) (
   input wire clk_i,
   input wire rst_b_i,
   // register port
   input wire [3:0] reg_addr_i,
   input wire [31:0] reg_wdata_i,
   input wire reg_we_i,
   input wire reg_re_i,
   output reg [31:0] reg_rdata_o,
   // enable pin and mode pins
   input wire enable_i,
   input wire deep_sleep_enable_n_i,
   input wire deeper_sleep_select_i,
   input wire [5:0] target_voltage_code_i,
   // comparators against the mode setpoint
   input wire boot_reached_i,
   input wire excess_cmp_i,
   input wire below_102_cmp_i,
   input wire low_voltage_cmp_i,
   // supply ok pin: sink current detect and line drive
   input wire supply_ok_sink_i,
   input wire supply_ok_pin_i,
   output reg supply_ok_pin_o,
   output reg supply_ok_pin_oe_o,
   // error amplifier duty and current samples
   input wire [15:0] duty_i,
   input wire [CUR_W-1:0] phase_current_sample_0_i,
   input wire [CUR_W-1:0] phase_current_sample_1_i,
   input wire [CUR_W-1:0] overcurrent_threshold_source_i,
   // gate drive and reference outputs
   output reg [1:0] pwm_o,
   output reg lowside_on_o,
   output reg gates_off_o,
   output reg [1:0] sample_en_o,
   output reg [1:0] mode_o,
   output reg [5:0] target_voltage_code_o,
   output reg use_boot_o
);

   // start-up states
   localparam [2:0] S_OFF = 3'd0;
   localparam [2:0] S_BOOT = 3'd1;
   localparam [2:0] S_WAIT = 3'd2;
   localparam [2:0] S_DELAY = 3'd3;
   localparam [2:0] S_GOOD = 3'd4;
   localparam [2:0] S_LATCH = 3'd5;
   localparam [15:0] HALF = PHASE_DIV >> 1;
   // suppression length, held at the width of its counter
   localparam [3:0] BLANK = `CRFS_BLANK_TICKS;

   // mode decode of the two sleep pins
   function [1:0] crfs_mode;
      input n_deep;
      input deeper;
      begin
         if (!n_deep && deeper) begin
            crfs_mode = `CRFS_MODE_DEEPER;
         end else if (!n_deep) begin
            crfs_mode = `CRFS_MODE_DEEP;
         end else begin
            crfs_mode = `CRFS_MODE_ACTIVE;
         end
      end
   endfunction

   // mean of the active channel samples
   function [CUR_W-1:0] crfs_mean;
      input [CUR_W-1:0] a;
      input [CUR_W-1:0] b;
      input two;
      reg [CUR_W:0] sum;
      begin
         sum = {1'b0, a} + {1'b0, b};
         crfs_mean = two ? sum[CUR_W:1] : a;
      end
   endfunction

   // synchroniser stages for comparator inputs
   reg [4:0] sync1_q; // first stage, read only by second
   reg [4:0] sync2_q; // usable comparator levels
   wire en_s = sync2_q[0];
   wire excess_s = sync2_q[1];
   wire b102_s = sync2_q[2];
   wire lowv_s = sync2_q[3];
   wire sink_s = sync2_q[4];

   // phase divider and ramps
   reg [15:0] ramp_q; // channel 0 ramp
   wire tick = (ramp_q == PHASE_DIV - 16'h0001);
   wire [15:0] ramp1; // channel 1 ramp, half a period later

   // control and state registers
   reg [1:0] ctrl_q; // software channel options
   reg [2:0] state_q;
   reg [11:0] timer_q; // supply ok delay timer
   reg [5:0] code_q; // captured target code
   reg captured_q; // boot voltage left
   reg excess_q; // excess voltage latch
   reg lowside_q; // low-side on within excess cycling
   reg lowv_lat_q; // low voltage shutdown latch
   reg oc_lat_q; // overcurrent shutdown latch
   reg [5:0] lowv_cnt_q; // consecutive low periods
   reg [5:0] oc_cnt_q; // up/down persistence count
   reg [3:0] blank_q; // suppression periods left
   reg [5:0] last_code_q; // code seen last cycle
   reg [1:0] last_mode_q; // mode seen last cycle
   reg [CUR_W-1:0] samp0_q;
   reg [CUR_W-1:0] samp1_q;
   reg [CUR_W-1:0] mean_q;

   wire [1:0] mode = crfs_mode(deep_sleep_enable_n_i,
      deeper_sleep_select_i); // R23
   wire two_ch = !ctrl_q[`CRFS_CTRL_FORCE_SINGLE] &&
      !(ctrl_q[`CRFS_CTRL_SLEEP_SINGLE] &&
      mode != `CRFS_MODE_ACTIVE);
   wire [1:0] pwm_raw;
   wire latched_off = lowv_lat_q | oc_lat_q;
   wire over = mean_q > overcurrent_threshold_source_i;
   wire change = (target_voltage_code_i != last_code_q) ||
      (mode != last_mode_q);

   // second ramp offset by half a period
   assign ramp1 = (ramp_q >= HALF) ? ramp_q - HALF : ramp_q + HALF; // R21
   assign pwm_raw[0] = ramp_q < duty_i;
   assign pwm_raw[1] = two_ch && (ramp1 < duty_i);

   // comparator synchroniser
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sync1_q <= 5'h00;
         sync2_q <= 5'h00;
      end else begin
         sync1_q <= {supply_ok_sink_i, low_voltage_cmp_i,
            below_102_cmp_i, excess_cmp_i, enable_i}; // R25
         sync2_q <= sync1_q;
      end
   end

   // phase divider: ticks once per switching period
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ramp_q <= 16'h0000;
      end else if (tick) begin
         ramp_q <= 16'h0000;
      end else begin
         ramp_q <= ramp_q + 16'h0001;
      end
   end

   // start-up sequence and shutdown latch state
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_q <= S_OFF; // R25
         timer_q <= 12'h000;
         code_q <= 6'h00;
         captured_q <= 1'b0;
      end else if (!en_s) begin
         // enable low restarts and clears shutdown
         state_q <= S_OFF; // R15
         captured_q <= 1'b0;
         timer_q <= 12'h000;
      end else begin
         case (state_q)
            S_OFF: begin
               state_q <= S_BOOT;
            end
            S_BOOT: begin
               // regulate at boot voltage until reached
               if (boot_reached_i) begin
                  state_q <= S_WAIT;
               end
            end
            S_WAIT: begin
               // companions released line, sink current flows
               if (sink_s) begin
                  state_q <= S_DELAY; // R1
                  timer_q <= 12'h000; // R2
                  code_q <= target_voltage_code_i; // R3
                  captured_q <= 1'b1; // R3
               end
            end
            S_DELAY: begin
               if (tick) begin
                  if (timer_q == PG_DELAY - 12'h001) begin
                     state_q <= S_GOOD; // R4
                  end else begin
                     timer_q <= timer_q + 12'h001; // R4
                  end
               end
            end
            S_GOOD: begin
               // code follows the pins once regulating
               code_q <= target_voltage_code_i; // R22
            end
            S_LATCH: begin
               state_q <= S_LATCH;
            end
            default: begin
               state_q <= S_OFF;
            end
         endcase
         if (latched_off) begin
            state_q <= S_LATCH;
         end
      end
   end

   // excess voltage latch, only reset clears it
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         excess_q <= 1'b0; // R11
         lowside_q <= 1'b0;
      end else begin
         if (excess_s) begin
            excess_q <= 1'b1; // R8
            lowside_q <= 1'b1; // R10
         end else if (excess_q && b102_s) begin
            lowside_q <= 1'b0; // R9
         end
      end
   end

   // low voltage persistence and latch
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         lowv_cnt_q <= 6'h00;
         lowv_lat_q <= 1'b0;
      end else if (!en_s) begin
         lowv_cnt_q <= 6'h00;
         lowv_lat_q <= 1'b0; // R15
      end else if (state_q == S_GOOD || state_q == S_DELAY) begin
         if (!lowv_s) begin
            lowv_cnt_q <= 6'h00;
         end else if (tick) begin
            if (lowv_cnt_q == `CRFS_LOWV_TICKS) begin
               lowv_lat_q <= 1'b1; // R14
            end else begin
               lowv_cnt_q <= lowv_cnt_q + 6'h01; // R13
            end
         end
      end
   end

   // overcurrent up/down counter and latch
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         oc_cnt_q <= 6'h00;
         oc_lat_q <= 1'b0;
      end else if (!en_s) begin
         oc_cnt_q <= 6'h00;
         oc_lat_q <= 1'b0;
      end else if (tick) begin
         if (over) begin
            if (oc_cnt_q == `CRFS_OC_TRIP - 1) begin // R26
               oc_lat_q <= 1'b1; // R18
            end
            if (oc_cnt_q != `CRFS_OC_TRIP) begin
               oc_cnt_q <= oc_cnt_q + 6'h01; // R17 R26
            end
         end else if (oc_cnt_q != 6'h00) begin
            oc_cnt_q <= oc_cnt_q - 6'h01; // R19
         end
      end
   end

   // off-time current sampling and averaging
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         samp0_q <= {CUR_W{1'b0}};
         samp1_q <= {CUR_W{1'b0}};
         mean_q <= {CUR_W{1'b0}};
      end else begin
         if (!pwm_raw[0]) begin
            samp0_q <= phase_current_sample_0_i; // R20
         end
         if (two_ch && !pwm_raw[1]) begin
            samp1_q <= phase_current_sample_1_i; // R20
         end
         mean_q <= crfs_mean(samp0_q, samp1_q, two_ch); // R16
      end
   end

   // suppression window after code or mode change
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         blank_q <= 4'h0;
         last_code_q <= 6'h00;
         last_mode_q <= `CRFS_MODE_ACTIVE;
      end else begin
         last_code_q <= target_voltage_code_i;
         last_mode_q <= mode;
         if (change) begin
            blank_q <= BLANK; // R6
         end else if (tick && blank_q != 4'h0) begin
            blank_q <= blank_q - 4'h1;
         end
      end
   end

   // registered pin, gate and reference outputs
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         supply_ok_pin_o <= 1'b0;
         supply_ok_pin_oe_o <= 1'b1;
         pwm_o <= 2'b00;
         lowside_on_o <= 1'b0;
         gates_off_o <= 1'b1;
         sample_en_o <= 2'b00;
         mode_o <= `CRFS_MODE_ACTIVE;
         target_voltage_code_o <= 6'h00;
         use_boot_o <= 1'b1;
      end else begin
         supply_ok_pin_o <= 1'b0;
         // pull low unless good, in window and not blanked
         // raw excess level too, so the line drops in the same cycle as the latch sets
         supply_ok_pin_oe_o <= (state_q != S_GOOD) || excess_q ||
            excess_s ||
            lowv_s || latched_off || change ||
            blank_q != 4'h0; // R5 R7 R24
         mode_o <= mode; // R12 R13
         target_voltage_code_o <= code_q; // R22
         use_boot_o <= !captured_q; // R3
         if (excess_q || excess_s) begin
            // modulation held low while latch set
            pwm_o <= 2'b00; // R8
            lowside_on_o <= excess_s || lowside_q; // R10
            gates_off_o <= !(excess_s || lowside_q); // R9
            sample_en_o <= 2'b00;
         end else if (state_q == S_OFF || state_q == S_LATCH) begin
            pwm_o <= 2'b00;
            lowside_on_o <= 1'b0;
            gates_off_o <= 1'b1;
            sample_en_o <= 2'b00;
         end else begin
            pwm_o <= pwm_raw;
            lowside_on_o <= 1'b0;
            gates_off_o <= 1'b0;
            sample_en_o <= {two_ch & ~pwm_raw[1], ~pwm_raw[0]}; // R20
         end
      end
   end

   // register writes
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl_q <= `CRFS_CTRL_RESET;
      end else if (reg_we_i && reg_addr_i == `CRFS_REG_CTRL) begin
         ctrl_q <= reg_wdata_i[1:0];
      end
   end

   // register reads, data one cycle after the strobe
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         reg_rdata_o <= 32'h0000_0000;
      end else if (reg_re_i) begin
         case (reg_addr_i)
            `CRFS_REG_CTRL: begin
               reg_rdata_o <= {30'h0000_0000, ctrl_q};
            end
            `CRFS_REG_STATUS: begin
               reg_rdata_o <= {24'h00_0000, !captured_q, oc_lat_q,
                  lowv_lat_q, excess_q, 1'b0, state_q};
            end
            `CRFS_REG_CODE: begin
               reg_rdata_o <= {26'h000_0000, code_q};
            end
            `CRFS_REG_MEAN: begin
               reg_rdata_o <= {{(32 - CUR_W){1'b0}}, mean_q};
            end
            default: begin
               reg_rdata_o <= 32'h0000_0000;
            end
         endcase
      end else begin
         reg_rdata_o <= 32'h0000_0000;
      end
   end

endmodule // crfs_supervisor

// ---- test/crfs_supervisor_sva.sv ----
// port checker for the supervisor, bound after the module
// assumes one clock domain and an active low async reset
`include "crfs_consts.vh"
module crfs_chk #(
   parameter [15:0] PHASE_DIV = 16'h03E8
) (
   input wire clk_i,
   input wire rst_b_i,
   input wire enable_i,
   input wire deep_sleep_enable_n_i,
   input wire deeper_sleep_select_i,
   input wire [5:0] target_voltage_code_i,
   input wire excess_cmp_i,
   input wire low_voltage_cmp_i,
   input wire supply_ok_pin_oe_o,
   input wire [1:0] pwm_o,
   input wire lowside_on_o,
   input wire gates_off_o,
   input wire [1:0] sample_en_o,
   input wire [1:0] mode_o,
   input wire use_boot_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // low voltage cycles after which a latch is certain
   localparam [15:0] LV_LIM = 16'(33 * PHASE_DIV + 8);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);
   // mode expected from the two sleep pins
   wire [1:0] exp_mode = deep_sleep_enable_n_i ? `CRFS_MODE_ACTIVE :
      (deeper_sleep_select_i ? `CRFS_MODE_DEEPER : `CRFS_MODE_DEEP);
   logic [15:0] lv_cnt_q; // cycles of continuous low voltage
   logic lv_trip_q; // low voltage outlasted the limit
   // count low voltage, forget the latch while enable is low
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         lv_cnt_q <= 16'h0000;
         lv_trip_q <= 1'b0;
      end else begin
         if (!low_voltage_cmp_i) lv_cnt_q <= 16'h0000;
         else if (lv_cnt_q != LV_LIM) lv_cnt_q <= lv_cnt_q + 16'h0001;
         if (!enable_i) lv_trip_q <= 1'b0;
         else if (lv_cnt_q == LV_LIM) lv_trip_q <= 1'b1;
      end
   end
   sequence s_capture;
      $fell(use_boot_o);
   endsequence
   sequence s_retarget;
      $changed(target_voltage_code_i) || $changed(mode_o);
   endsequence
   sequence s_out_window;
      (low_voltage_cmp_i || excess_cmp_i) [*4];
   endsequence
   chk_boot_hold: assert property (use_boot_o |-> supply_ok_pin_oe_o)
      else $error("supply ok released during boot");
   chk_delay_min: assert property (s_capture |-> supply_ok_pin_oe_o [*8])
      else $error("supply ok released early");
   chk_blank_change: assert property (
      s_retarget |-> ##[0:4] supply_ok_pin_oe_o [*8])
      else $error("no blanking after change");
   chk_window_drop: assert property (s_out_window |-> supply_ok_pin_oe_o)
      else $error("supply ok kept outside window");
   chk_excess_drive: assert property (
      excess_cmp_i [*4] |-> pwm_o == 2'b00 && lowside_on_o)
      else $error("excess without low side drive");
   chk_gates_excl: assert property (!(lowside_on_o && gates_off_o))
      else $error("low side on with gates off");
   chk_sample_off: assert property ((sample_en_o & pwm_o) == 2'b00)
      else $error("sampling during on time");
   chk_mode_decode: assert property (
      $stable({deep_sleep_enable_n_i, deeper_sleep_select_i}) [*4]
      |-> mode_o == exp_mode)
      else $error("mode decode wrong");
   chk_lowv_latch: assert property (lv_trip_q |-> supply_ok_pin_oe_o)
      else $error("low voltage not latched");
endmodule // crfs_chk

bind crfs_supervisor crfs_chk #(.PHASE_DIV(PHASE_DIV)) i_crfs_chk (
   .clk_i(clk_i), .rst_b_i(rst_b_i), .enable_i(enable_i),
   .deep_sleep_enable_n_i(deep_sleep_enable_n_i),
   .deeper_sleep_select_i(deeper_sleep_select_i),
   .target_voltage_code_i(target_voltage_code_i),
   .excess_cmp_i(excess_cmp_i), .low_voltage_cmp_i(low_voltage_cmp_i),
   .supply_ok_pin_oe_o(supply_ok_pin_oe_o), .pwm_o(pwm_o),
   .lowside_on_o(lowside_on_o), .gates_off_o(gates_off_o),
   .sample_en_o(sample_en_o), .mode_o(mode_o), .use_boot_o(use_boot_o));

// ---- test/crfs_companion_model.sv ----
// two companion regulators on the shared supply ok line
// assumes a pull-up on the line and the device's pull-down enable
module crfs_companion_model (
   input wire clk_i,
   input wire [1:0] in_window_i, // each companion inside its window
   input wire dut_oe_i, // device pulling the line low
   output logic sink_o = 1'b0, // pull-up current into the device
   output wire line_o // resolved line level
);
   timeunit 1ns;
   timeprecision 1ps;
   logic pull_low = 1'b1; // a companion sinks the line
   // open drain: low if anybody pulls
   assign line_o = !(pull_low || dut_oe_i);
   // companions out of window hold the line low
   always @(posedge clk_i) begin
      pull_low <= !(&in_window_i);
      sink_o <= !pull_low && dut_oe_i;
   end
endmodule // crfs_companion_model

// ---- test/crfs_supervisor_tb.sv ----
// bench for the supervisor with the companion line model
// assumes 8 clocks per period and a delay of 4 periods
`include "crfs_consts.vh"
module crfs_supervisor_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PD = 8; // clocks per switching period
   localparam int PG = 4; // periods of supply ok delay
   logic clk = 1'b0, rst_b = 1'b0, we = 1'b0, re = 1'b0; // clock, bus
   logic en = 1'b1, dsn = 1'b1, drs = 1'b0, boot = 1'b0; // pins
   logic exc = 1'b0, b102 = 1'b0, lv = 1'b0; // comparator results
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0000_0000, d, r; // write, read, random
   logic [5:0] code = 6'h2A; // target code on the pins
   logic [15:0] duty = 16'h0002;
   logic [7:0] s0 = 8'h10, s1 = 8'h10, thr = 8'hFF; // currents
   logic [1:0] comp_ok = 2'b00; // companions in window
   logic [1:0] mseq [4] = '{2'b00, 2'b11, 2'b01, 2'b10}; // pin pairs
   logic [31:0] seed = 32'h0000_A0C1; // xorshift start
   wire [31:0] rdata;
   wire [5:0] code_o;
   wire [1:0] pwm, sen, mode;
   wire sink, line, oe, pin_o, lso, goff, ub;
   wire [3:0] obs = {goff, lso, ub, oe}; // outputs waited on
   int miscompares = 0, n_checks = 0, t;
   // clock, 4 ns period
   always #2 clk = ~clk;
   crfs_supervisor #(.PHASE_DIV(16'h0008), .PG_DELAY(12'h004), .CUR_W(8))
   i_crfs_supervisor (.clk_i(clk), .rst_b_i(rst_b), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re),
      .reg_rdata_o(rdata), .enable_i(en), .deep_sleep_enable_n_i(dsn),
      .deeper_sleep_select_i(drs), .target_voltage_code_i(code),
      .boot_reached_i(boot), .excess_cmp_i(exc), .below_102_cmp_i(b102),
      .low_voltage_cmp_i(lv), .supply_ok_sink_i(sink),
      .supply_ok_pin_i(line), .supply_ok_pin_o(pin_o),
      .supply_ok_pin_oe_o(oe), .duty_i(duty),
      .phase_current_sample_0_i(s0), .phase_current_sample_1_i(s1),
      .overcurrent_threshold_source_i(thr), .pwm_o(pwm),
      .lowside_on_o(lso), .gates_off_o(goff), .sample_en_o(sen),
      .mode_o(mode), .target_voltage_code_o(code_o), .use_boot_o(ub));
   crfs_companion_model i_crfs_companion_model (.clk_i(clk),
      .in_window_i(comp_ok), .dut_oe_i(oe), .sink_o(sink), .line_o(line));
   // compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: %h not %h", $time, seen, exp);
      end
   endtask
   // counts, verdict, stop
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // xorshift random source
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // mode the pins should select
   function automatic logic [1:0] exp_mode(input logic [1:0] p);
      if (p[1]) return `CRFS_MODE_ACTIVE;
      return p[0] ? `CRFS_MODE_DEEPER : `CRFS_MODE_DEEP;
   endfunction
   // let n edges pass, then settle
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // one-cycle write strobe
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      addr <= a;
      wdata <= v;
      we <= 1'b1;
      cyc(1);
      we <= 1'b0;
   endtask
   // one-cycle read strobe, data in the next cycle
   task automatic rd(input logic [3:0] a);
      addr <= a;
      re <= 1'b1;
      @(posedge clk);
      re <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic rchk(input logic [3:0] a, input logic [31:0] e);
      rd(a);
      chk(d, e);
   endtask
   // bounded wait for obs[k] == v, cycles left in t
   task automatic wait_bit(input int k, input logic v, input int lim);
      t = 0;
      while (obs[k] !== v) begin
         if (t == lim) begin
            miscompares++;
            end_of_test();
         end
         cyc(1);
         t++;
      end
   endtask
   // boot, companions late, then the delay to supply ok
   task automatic start_up();
      comp_ok <= 2'b01;
      boot <= 1'b0;
      en <= 1'b1;
      cyc(4);
      boot <= 1'b1;
      cyc(3 * PD);
      chk({ub, oe, pin_o}, 3'b110);
      comp_ok <= 2'b11;
      wait_bit(1, 1'b0, 20);
      chk(code_o, code);
      wait_bit(0, 1'b0, PD * PG + 8);
      chk(t >= PD * (PG - 1) && t <= PD * PG + 3, 1'b1);
      rchk(`CRFS_REG_CODE, {26'h0, code});
      rchk(`CRFS_REG_STATUS, 32'h0000_0004);
      $display("test start_up done");
   endtask
   initial begin
      cyc(5);
      chk({oe, goff, ub, pwm}, 5'b11100);
      rst_b <= 1'b1;
      rchk(`CRFS_REG_CTRL, {30'h0, `CRFS_CTRL_RESET});
      wr(`CRFS_REG_CODE, 32'hFFFF_FFFF);
      rchk(`CRFS_REG_CODE, 32'h0000_0000);
      rchk(4'h2, 32'h0000_0000);
      start_up();
      comp_ok <= 2'b10;
      cyc(2);
      chk(line, 1'b0);
      comp_ok <= 2'b11;
      // mean of active channels, two then one
      for (int i = 0; i < 2; i++) begin
         r = rnd();
         s0 <= r[7:0];
         s1 <= r[15:8];
         duty <= {14'h0, r[17:16]};
         wr(`CRFS_REG_CTRL, {30'h0, i[0], 1'b0});
         cyc(4 * PD);
         rchk(`CRFS_REG_MEAN, i ? {24'h0, s0} : ({24'h0, s0} + s1) >> 1);
      end
      wr(`CRFS_REG_CTRL, 32'h0000_0000);
      // every pin pair, then a code change, each blanks
      foreach (mseq[j]) begin
         {dsn, drs} <= mseq[j];
         cyc(6);
         chk(mode, exp_mode(mseq[j]));
         chk(oe, 1'b1);
         wait_bit(0, 1'b0, 12 * PD);
      end
      code <= code ^ 6'h15;
      cyc(6);
      chk(oe, 1'b1);
      wait_bit(0, 1'b0, 12 * PD);
      $display("test modes done");
      // overcurrent: short burst forgiven, long one latches
      s0 <= 8'h64;
      s1 <= 8'h64;
      thr <= 8'h63;
      cyc(20 * PD);
      thr <= 8'h65;
      cyc(40 * PD);
      chk(oe, 1'b0);
      thr <= 8'h63;
      wait_bit(0, 1'b1, 40 * PD);
      chk(t >= 30 * PD, 1'b1);
      rchk(`CRFS_REG_STATUS, 32'h0000_0045);
      thr <= 8'hFF;
      en <= 1'b0;
      cyc(4);
      start_up();
      // low voltage: short dip survived, long one latches
      lv <= 1'b1;
      cyc(20 * PD);
      chk(oe, 1'b1);
      lv <= 1'b0;
      cyc(4 * PD);
      rchk(`CRFS_REG_STATUS, 32'h0000_0004);
      lv <= 1'b1;
      cyc(36 * PD);
      lv <= 1'b0;
      cyc(4 * PD);
      rchk(`CRFS_REG_STATUS, 32'h0000_0025);
      en <= 1'b0;
      cyc(4);
      start_up();
      // excess: low side on, gates off below 102, cycling
      exc <= 1'b1;
      cyc(4);
      chk({pwm, lso, goff}, 4'b0010);
      exc <= 1'b0;
      b102 <= 1'b1;
      cyc(4);
      chk({pwm, lso, goff}, 4'b0001);
      exc <= 1'b1;
      b102 <= 1'b0;
      cyc(4);
      chk({pwm, lso, goff}, 4'b0010);
      exc <= 1'b0;
      b102 <= 1'b1;
      en <= 1'b0;
      cyc(4);
      en <= 1'b1;
      cyc(4);
      rd(`CRFS_REG_STATUS);
      chk({d[4], pwm}, 3'b100);
      rst_b <= 1'b0;
      cyc(5);
      chk({oe, goff, ub, pwm}, 5'b11100);
      rst_b <= 1'b1;
      rd(`CRFS_REG_STATUS);
      chk(d[4], 1'b0);
      $display("test faults done");
      end_of_test();
   end
endmodule // crfs_supervisor_tb
